// ### design/fcs_flash_seq.sv
// Flash command sequencer: register port, command entry and timing.
// Array writes, stop and security inputs come from logic on clk.
//
// Functional notes
// - Divider set first; program/erase refused before
// - Divider register takes one write only
// - Divider writes ignored while access error
// - Operations timed: 9, 4000, 20000 ticks
// - Array write latches address and data
// - Codes 05, 20, 25 accepted
// - Codes 40, 41 accepted
// - Writing one to empty flag launches
// - Writing zero to empty flag aborts
// - Complete flag shows command finished
// - Error cleared by one; blocks commands
// - Array write before divider sets error
// - Array write with buffer full errors
// - Second array or command write errors
// - Stray control write mid-sequence errors
// - Unknown command code sets error
// - Stop during program/erase aborts, errors
// - Secured debug: only blank, mass erase
// - Pump kept on: any queued program/erase
// - Burst byte 4 ticks after burst in same row; first or row start standard
// - No queued program/erase: pump switched off
module fcs_flash_seq #(
    parameter int ADDR_W = 13
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [1:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic              array_wr,
    input  wire logic [ADDR_W-1:0] array_addr,
    input  wire logic [7:0]        array_wdata,
    input  wire logic              bdm_access,
    input  wire logic              secured,
    input  wire logic              stop_req,
    output logic                   op_busy,
    output logic                   pump_on,
    output logic      [7:0]        op_cmd,
    output logic      [ADDR_W-1:0] op_addr,
    output logic      [7:0]        op_data,
    output logic                   timing_tick
);
    // ==========================================================
    // Elaboration check
    if (ADDR_W <= fcs_pkg::ROW_LSB) begin : g_bad_addr_w
        $error("ADDR_W too small for a row");
    end

    // ==========================================================
    // Decoded strobes
    logic wr_div;
    logic wr_stat;
    logic wr_cmd;
    logic cbe;
    logic cc;
    logic err;
    logic div_loaded;
    logic [fcs_pkg::DIV_W-1:0] div_val;
    fcs_pkg::fcs_seq_t seq;
    logic [7:0]        buf_cmd;
    logic [ADDR_W-1:0] buf_addr;
    logic [7:0]        buf_data;
    logic pend;
    logic [fcs_pkg::TW-1:0] tcnt;
    logic [fcs_pkg::DIV_W-1:0] dcnt;
    logic done;
    logic start;
    logic keep_pump;
    logic stop_abort;
    logic code_ok;
    logic code_locked;
    logic [fcs_pkg::TW-1:0] next_len;

    assign wr_div  = reg_wr && reg_addr == fcs_pkg::OFF_DIV;
    assign wr_stat = reg_wr && reg_addr == fcs_pkg::OFF_STAT;
    assign wr_cmd  = reg_wr && reg_addr == fcs_pkg::OFF_CMD;

    // ==========================================================
    // Divider register
    // one write only; blocked by error
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            div_loaded <= 1'b0;
            div_val    <= fcs_pkg::DIV_RST;
        end
        else if (wr_div && !div_loaded && !err)
        begin
            div_loaded <= 1'b1;
            div_val    <= reg_wdata[fcs_pkg::DIV_W-1:0];
        end
    end

    // ==========================================================
    // Timing clock enable, period div_val+1 bus cycles
    // tick runs only once divider is set
    always_ff @(posedge clk)
    begin
        if (rst || !div_loaded)
            dcnt <= '0;
        else if (dcnt >= div_val)
            dcnt <= '0;
        else
            dcnt <= dcnt + 1'b1;
    end
    assign timing_tick = div_loaded && dcnt >= div_val;

    // ==========================================================
    // Command code checks
    // five valid codes
    assign code_ok = reg_wdata == fcs_pkg::CMD_BLANK ||
                     reg_wdata == fcs_pkg::CMD_BYTE  ||
                     reg_wdata == fcs_pkg::CMD_BURST ||
                     reg_wdata == fcs_pkg::CMD_PAGE  ||
                     reg_wdata == fcs_pkg::CMD_MASS;
    assign code_locked = secured && bdm_access &&
                         (reg_wdata == fcs_pkg::CMD_BYTE  ||
                          reg_wdata == fcs_pkg::CMD_BURST ||
                          reg_wdata == fcs_pkg::CMD_PAGE);

    // ==========================================================
    // Error detection; set wins over clear
    logic err_set;
    always_comb
    begin
        err_set = 1'b0;
        if (array_wr && !err && seq == fcs_pkg::FCS_SEQ_IDLE &&
            (!div_loaded || !cbe))
            err_set = 1'b1;
        if (array_wr && seq != fcs_pkg::FCS_SEQ_IDLE)
            err_set = 1'b1;
        // stray control writes after array write
        if (seq == fcs_pkg::FCS_SEQ_ADDR && (wr_div || wr_stat))
            err_set = 1'b1;
        if (seq == fcs_pkg::FCS_SEQ_ADDR && wr_cmd &&
            (!code_ok || code_locked))
            err_set = 1'b1;
        // after command write only launch allowed
        if (seq == fcs_pkg::FCS_SEQ_CMD && (wr_div || wr_cmd ||
            (wr_stat && !reg_wdata[fcs_pkg::STAT_CBE_BIT])))
            err_set = 1'b1;
        if (stop_abort)
            err_set = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            err <= 1'b0;
        else if (err_set)
            err <= 1'b1;
        else if (wr_stat && reg_wdata[fcs_pkg::STAT_ERR_BIT])
            err <= 1'b0;
    end

    // ==========================================================
    // Command entry sequence
    always_ff @(posedge clk)
    begin
        if (rst || err_set)
            seq <= fcs_pkg::FCS_SEQ_IDLE;
        else
        begin
            case (seq)
                fcs_pkg::FCS_SEQ_IDLE:
                    if (array_wr && !err && div_loaded && cbe)
                        seq <= fcs_pkg::FCS_SEQ_ADDR;
                fcs_pkg::FCS_SEQ_ADDR:
                    if (wr_cmd)
                        seq <= fcs_pkg::FCS_SEQ_CMD;
                fcs_pkg::FCS_SEQ_CMD:
                    if (wr_stat)
                        seq <= fcs_pkg::FCS_SEQ_IDLE;
                default:
                    seq <= fcs_pkg::FCS_SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            buf_addr <= '0;
            buf_data <= 8'h00;
        end
        else if (array_wr && seq == fcs_pkg::FCS_SEQ_IDLE &&
                 !err && div_loaded && cbe)
        begin
            buf_addr <= array_addr;
            buf_data <= array_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            buf_cmd <= 8'h00;
        else if (wr_cmd && seq == fcs_pkg::FCS_SEQ_ADDR && !err_set)
            buf_cmd <= reg_wdata;
    end

    // ==========================================================
    // Launch, buffer flag and pending command
    logic launch;
    assign launch = seq == fcs_pkg::FCS_SEQ_CMD && !err_set && wr_stat;
    assign done   = op_busy && timing_tick && tcnt == fcs_pkg::T_ONE;
    assign start  = pend && (!op_busy || done) && !stop_abort;
    assign stop_abort = stop_req && op_busy &&
                        op_cmd != fcs_pkg::CMD_BLANK;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cbe  <= 1'b1;
            pend <= 1'b0;
        end
        else if (stop_abort)
        begin
            cbe  <= 1'b1;
            pend <= 1'b0;
        end
        else if (launch)
        begin
            cbe  <= 1'b0;
            pend <= 1'b1;
        end
        else if (start)
        begin
            cbe  <= 1'b1;
            pend <= 1'b0;
        end
    end

    // ==========================================================
    // Execution and charge pump
    // burst continues in same row, not at row start
    assign keep_pump = done && pump_on &&
        op_cmd == fcs_pkg::CMD_BURST && buf_cmd == fcs_pkg::CMD_BURST &&
        buf_addr[ADDR_W-1:fcs_pkg::ROW_LSB] ==
            op_addr[ADDR_W-1:fcs_pkg::ROW_LSB] &&
        buf_addr[fcs_pkg::ROW_LSB-1:0] != '0;

    always_comb
    begin
        case (buf_cmd)
            fcs_pkg::CMD_BYTE:  next_len = fcs_pkg::T_BYTE;
            fcs_pkg::CMD_BURST: next_len = keep_pump ? fcs_pkg::T_BURST
                                                     : fcs_pkg::T_BYTE;
            fcs_pkg::CMD_PAGE:  next_len = fcs_pkg::T_PAGE;
            fcs_pkg::CMD_MASS:  next_len = fcs_pkg::T_MASS;
            default:            next_len = fcs_pkg::T_BLANK;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst || stop_abort)
        begin
            op_busy <= 1'b0;
            pump_on <= 1'b0;
            tcnt    <= '0;
        end
        else if (start)
        begin
            op_busy <= 1'b1;
            pump_on <= buf_cmd != fcs_pkg::CMD_BLANK;
            tcnt    <= next_len;
        end
        else if (done)
        begin
            op_busy <= 1'b0;
            pump_on <= 1'b0;
            tcnt    <= '0;
        end
        else if (op_busy && timing_tick)
            tcnt <= tcnt - 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            op_cmd  <= 8'h00;
            op_addr <= '0;
            op_data <= 8'h00;
        end
        else if (start)
        begin
            op_cmd  <= buf_cmd;
            op_addr <= buf_addr;
            op_data <= buf_data;
        end
    end

    // complete when nothing runs or waits
    assign cc = !op_busy && !pend;

    // ==========================================================
    // Read port, data one cycle after strobe
    always_ff @(posedge clk)
    begin
        if (rst || !reg_rd)
            reg_rdata <= 8'h00;
        else
        begin
            case (reg_addr)
                fcs_pkg::OFF_DIV:  reg_rdata <= {div_loaded, div_val};
                fcs_pkg::OFF_STAT: reg_rdata <= {cbe, cc, 1'b0, err,
                                                 4'h0};
                fcs_pkg::OFF_CMD:  reg_rdata <= buf_cmd;
                default:           reg_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Checks
    sequence s_launch;
        seq == fcs_pkg::FCS_SEQ_CMD && wr_stat &&
        reg_wdata[fcs_pkg::STAT_CBE_BIT];
    endsequence
    sequence s_taken;
        !cbe ##1 cbe;
    endsequence

    property p_div_once;
        @(posedge clk) disable iff (rst)
        div_loaded |=> $stable(div_val);
    endproperty
    a_div_once: assert property (p_div_once)
        else $error("divider changed after load");

    property p_div_err;
        @(posedge clk) disable iff (rst)
        (err && !div_loaded) |=> !div_loaded;
    endproperty
    a_div_err: assert property (p_div_err)
        else $error("divider loaded during error");

    property p_early_array;
        @(posedge clk) disable iff (rst)
        (array_wr && !err && !div_loaded && seq == fcs_pkg::FCS_SEQ_IDLE)
            |=> err;
    endproperty
    a_early_array: assert property (p_early_array)
        else $error("early array write not flagged");

    property p_launch;
        @(posedge clk) disable iff (rst)
        s_launch ##1 !err |-> !cbe ##0 pend;
    endproperty
    a_launch: assert property (p_launch)
        else $error("launch did not queue command");

    property p_abort;
        @(posedge clk) disable iff (rst)
        (seq == fcs_pkg::FCS_SEQ_ADDR && wr_stat &&
         !reg_wdata[fcs_pkg::STAT_CBE_BIT])
            |=> err && seq == fcs_pkg::FCS_SEQ_IDLE;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort did not flag error");

    property p_bad_code;
        @(posedge clk) disable iff (rst)
        (seq == fcs_pkg::FCS_SEQ_ADDR && wr_cmd && !code_ok) |=> err;
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("bad code accepted");

    property p_stop;
        @(posedge clk) disable iff (rst)
        stop_abort |=> !op_busy && !pump_on && err;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not abort");

    property p_pump_off;
        @(posedge clk) disable iff (rst)
        (done && !pend && !launch) |=> !pump_on && cc;
    endproperty
    a_pump_off: assert property (p_pump_off)
        else $error("pump left on");

    property p_burst_len;
        @(posedge clk) disable iff (rst)
        (start && keep_pump) |=> tcnt == fcs_pkg::T_BURST && pump_on;
    endproperty
    a_burst_len: assert property (p_burst_len)
        else $error("burst length wrong");

    property p_refill;
        @(posedge clk) disable iff (rst)
        (start && !stop_abort) |=> cbe && op_busy;
    endproperty
    a_refill: assert property (p_refill)
        else $error("buffer not freed on start");

    // Idle launch starts next cycle, so the flag is low one cycle
    property p_taken;
        @(posedge clk) disable iff (rst)
        (launch && !op_busy) |=> s_taken;
    endproperty
    a_taken: assert property (p_taken)
        else $error("idle launch did not free buffer");

    property p_err_block;
        @(posedge clk) disable iff (rst)
        (err && seq == fcs_pkg::FCS_SEQ_IDLE && array_wr)
            |=> seq == fcs_pkg::FCS_SEQ_IDLE;
    endproperty
    a_err_block: assert property (p_err_block)
        else $error("command taken during error");

endmodule // fcs_flash_seq

// ### dv/fcs_cpu_model.sv
// Model of the CPU side: issues flash array writes to the sequencer.
// Assumes the sequencer's clk; one array write per call.
module fcs_cpu_model #(
    parameter int ADDR_W = 13
) (
    input  wire logic              clk,
    output logic                   array_wr,
    output logic      [ADDR_W-1:0] array_addr,
    output logic      [7:0]        array_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        array_wr    = 1'b0;
        array_addr  = '0;
        array_wdata = 8'h00;
    end

    // ==========================================================
    // Array write
    // one write, fresh bytes only
    task automatic arr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        array_wr    <= 1'b1;
        array_addr  <= a;
        array_wdata <= d;
        @(posedge clk);
        array_wr    <= 1'b0;
        // Released lines flip, so stale values never look valid
        array_addr  <= ~a;
        array_wdata <= ~d;
    endtask
endmodule // fcs_cpu_model

// ### dv/testbench.sv
// Self-checking bench for the flash command sequencer.
// Assumes divider value 0, so one timing tick per clk cycle.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [7:0]  code;
        logic [12:0] addr;
        logic [7:0]  data;
        logic [14:0] ticks;
        logic        pump;
    } fcs_row_t;

    logic        clk, rst, reg_wr, reg_rd, bdm_access, secured, stop_req;
    logic [1:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, op_cmd, op_data, array_wdata;
    logic        array_wr, op_busy, pump_on, timing_tick;
    logic [12:0] array_addr, op_addr;
    int          failures, comparisons, cycles, busy_cyc, pump_cyc;
    fcs_row_t    rows [5];

    fcs_flash_seq #(.ADDR_W(13)) i_fcs_flash_seq (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .array_wr(array_wr), .array_addr(array_addr),
        .array_wdata(array_wdata), .bdm_access(bdm_access),
        .secured(secured), .stop_req(stop_req), .op_busy(op_busy),
        .pump_on(pump_on), .op_cmd(op_cmd), .op_addr(op_addr),
        .op_data(op_data), .timing_tick(timing_tick)
    );

    fcs_cpu_model #(.ADDR_W(13)) i_fcs_cpu_model (
        .clk(clk), .array_wr(array_wr), .array_addr(array_addr),
        .array_wdata(array_wdata)
    );

    // ==========================================================
    // Clock, cycle counters, timeout
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (op_busy === 1'b1) busy_cyc++;
        if (pump_on === 1'b1) pump_cyc++;
        // Longest run is mass erase plus a few thousand cycles
        if (cycles > 40000)
        begin
            failures++;
            stop_test();
        end
    end

    // ==========================================================
    // Tasks
    task automatic stop_test();
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(16'(reg_rdata), 16'(e));
    endtask

    task automatic launch(input logic [7:0] c, input logic [12:0] a,
                          input logic [7:0] d);
        i_fcs_cpu_model.arr(a, d);
        wr(fcs_pkg::OFF_CMD, c);
        wr(fcs_pkg::OFF_STAT, 8'h80);
    endtask

    task automatic wait_busy();
        for (int n = 0; n < 20 && op_busy !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic wait_idle();
        for (int n = 0; n < 30000 && op_busy !== 1'b0; n++)
        begin
            @(posedge clk);
            #1;
        end
        repeat (3) @(posedge clk);
    endtask

    // error seen, then cleared by one
    task automatic err_clear();
        rd(fcs_pkg::OFF_STAT, 8'hD0);
        wr(fcs_pkg::OFF_STAT, 8'h10);
        rd(fcs_pkg::OFF_STAT, 8'hC0);
        chk(16'(op_busy), 16'h0000);
    endtask

    task automatic bad(input int k);
        i_fcs_cpu_model.arr(13'h0700, 8'h77);
        case (k)
            0: wr(fcs_pkg::OFF_CMD, 8'h33);
            1: wr(fcs_pkg::OFF_STAT, 8'h00);
            2: i_fcs_cpu_model.arr(13'h0701, 8'h78);
            3: wr(fcs_pkg::OFF_DIV, 8'h00);
            default: wr(fcs_pkg::OFF_CMD, fcs_pkg::CMD_BYTE);
        endcase
        if (k == 4) wr(fcs_pkg::OFF_CMD, fcs_pkg::CMD_BYTE);
        if (k == 5) wr(fcs_pkg::OFF_DIV, 8'h00);
        err_clear();
    endtask

    task automatic burst_pair(input logic [12:0] a, input int busy_exp);
        busy_cyc = 0;
        pump_cyc = 0;
        launch(fcs_pkg::CMD_BURST, a, 8'h5A);
        wait_busy();
        launch(fcs_pkg::CMD_BURST, a + 13'h0001, 8'hA5);
        wait_idle();
        chk(16'(busy_cyc), 16'(busy_exp));
        chk(16'(pump_on), 16'h0000);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        rst = 1'b1;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        bdm_access = 1'b0;
        secured = 1'b0;
        stop_req = 1'b0;
        rows[0] = '{fcs_pkg::CMD_BLANK, 13'h0100, 8'hA5,
                    fcs_pkg::T_BLANK, 1'b0};
        rows[1] = '{fcs_pkg::CMD_BYTE, 13'h0200, 8'h5A,
                    fcs_pkg::T_BYTE, 1'b1};
        rows[2] = '{fcs_pkg::CMD_BURST, 13'h0300, 8'h3C,
                    fcs_pkg::T_BYTE, 1'b1};
        rows[3] = '{fcs_pkg::CMD_PAGE, 13'h04C7, 8'hFF,
                    fcs_pkg::T_PAGE, 1'b1};
        rows[4] = '{fcs_pkg::CMD_MASS, 13'h1FFF, 8'h00,
                    fcs_pkg::T_MASS, 1'b1};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(fcs_pkg::OFF_STAT, 8'hC0);
        rd(fcs_pkg::OFF_DIV, 8'h00);
        i_fcs_cpu_model.arr(13'h0010, 8'h11);
        wr(fcs_pkg::OFF_DIV, 8'h00);
        rd(fcs_pkg::OFF_STAT, 8'hD0);
        rd(fcs_pkg::OFF_DIV, 8'h00);
        wr(fcs_pkg::OFF_STAT, 8'h10);
        rd(fcs_pkg::OFF_STAT, 8'hC0);
        wr(fcs_pkg::OFF_DIV, 8'h00);
        wr(fcs_pkg::OFF_DIV, 8'h05);
        rd(fcs_pkg::OFF_DIV, 8'h80);
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'h00);
        foreach (rows[i])
        begin
            busy_cyc = 0;
            pump_cyc = 0;
            launch(rows[i].code, rows[i].addr, rows[i].data);
            wait_busy();
            chk(16'(op_cmd), 16'(rows[i].code));
            chk(16'(op_addr), 16'(rows[i].addr));
            chk(16'(op_data), 16'(rows[i].data));
            wait_idle();
            chk(16'(busy_cyc), 16'(rows[i].ticks));
            chk(16'(pump_cyc), rows[i].pump ? 16'(rows[i].ticks) : 16'h0);
            rd(fcs_pkg::OFF_STAT, 8'hC0);
        end
        for (int k = 0; k < 6; k++)
            bad(k);
        launch(fcs_pkg::CMD_PAGE, 13'h0600, 8'h00);
        wait_busy();
        rd(fcs_pkg::OFF_STAT, 8'h80);
        // Queue a second erase, then write the array with buffer full
        launch(fcs_pkg::CMD_PAGE, 13'h0A00, 8'h00);
        rd(fcs_pkg::OFF_STAT, 8'h00);
        i_fcs_cpu_model.arr(13'h0A01, 8'h00);
        rd(fcs_pkg::OFF_STAT, 8'h10);
        @(posedge clk);
        stop_req <= 1'b1;
        repeat (3) @(posedge clk);
        stop_req <= 1'b0;
        #1;
        chk(16'({op_busy, pump_on}), 16'h0000);
        err_clear();
        @(posedge clk);
        secured <= 1'b1;
        bdm_access <= 1'b1;
        foreach (rows[i])
        begin
            if (i >= 1 && i <= 3)
            begin
                i_fcs_cpu_model.arr(13'h0800, 8'h00);
                wr(fcs_pkg::OFF_CMD, rows[i].code);
                err_clear();
            end
        end
        launch(fcs_pkg::CMD_BLANK, 13'h0800, 8'h00);
        wait_busy();
        chk(16'(op_cmd), 16'(fcs_pkg::CMD_BLANK));
        wait_idle();
        secured <= 1'b0;
        bdm_access <= 1'b0;
        burst_pair(13'h0881, fcs_pkg::T_BYTE + fcs_pkg::T_BURST);
        chk(16'(pump_cyc), 16'(busy_cyc));
        burst_pair(13'h08BF, 2 * fcs_pkg::T_BYTE);
        stop_test();
    end
endmodule // testbench

// ### include/fcs_pkg.sv
// Constants for the flash command sequencer.
// Assumes a single bus clock and byte-wide control registers.
package fcs_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [1:0] OFF_DIV  = 2'h0;
    localparam logic [1:0] OFF_STAT = 2'h1;
    localparam logic [1:0] OFF_CMD  = 2'h2;
    // ==========================================================
    // Field positions
    localparam int DIV_LOADED_BIT = 7;
    localparam int DIV_W          = 7;
    localparam int STAT_CBE_BIT   = 7;
    localparam int STAT_CC_BIT    = 6;
    localparam int STAT_ERR_BIT   = 4;
    localparam int ROW_LSB        = 6;
    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_BLANK = 8'h05;
    localparam logic [7:0] CMD_BYTE  = 8'h20;
    localparam logic [7:0] CMD_BURST = 8'h25;
    localparam logic [7:0] CMD_PAGE  = 8'h40;
    localparam logic [7:0] CMD_MASS  = 8'h41;
    // ==========================================================
    // Operation lengths in timing clock periods
    localparam int TW = 15;
    localparam logic [TW-1:0] T_BYTE  = 15'h0009;
    localparam logic [TW-1:0] T_BURST = 15'h0004;
    localparam logic [TW-1:0] T_PAGE  = 15'h0FA0;
    localparam logic [TW-1:0] T_MASS  = 15'h4E20;
    localparam logic [TW-1:0] T_BLANK = 15'h0001;
    localparam logic [TW-1:0] T_ONE   = 15'h0001;
    // ==========================================================
    // Reset values
    localparam logic [DIV_W-1:0] DIV_RST = 7'h00;
    // ==========================================================
    // Command entry sequence
    typedef enum logic [1:0] {
        FCS_SEQ_IDLE = 2'b00,
        FCS_SEQ_ADDR = 2'b01,
        FCS_SEQ_CMD  = 2'b10
    } fcs_seq_t;
endpackage
